// ### common/hw_mode_strap_regs.vh
// Operation
// - In hardware mode the transmit PLL always takes the external transmit clock pin.
// - Clock source strap 00 ext pin, 01 PLL, 10 scaled master, 11 recovered.
// - PLL clock output pin carries the same clock selected for transmit.
// - Hardware mode derives internal termination from selected receive and transmit modes.
// - Transmit termination enabled when its disable strap is 0; value follows tx mode.
// - Receive termination enabled when its disable strap is 0; value follows rx mode.
// - E1 with termination enabled: impedance strap 0 gives 75 ohm, 1 gives 120.
// - One E1 impedance strap serves both transmit and receive directions.
// - Interrupt pin is active-low output in port modes, jitter clock select 0 in hardware.
// - Select pin is chip select in port modes, remote loopback enable in hardware.
// - Bus type pin picks bus timing in parallel, line code enable in hardware.
// - Two dedicated pins give transmit mode bits 2 and 1 in hardware mode.
// - Read strobe pin is read strobe in parallel, receive mode bit 2 in hardware.
// - Write strobe pin is write strobe in parallel, transmit mode bit 3 in hardware.
// - Address/data bit 0 is serial data out in serial, clock source low bit in hardware.
// - Address/data bit 1 is serial data in in serial, receive mode bit 3 in hardware.
// - Two interface select inputs choose parallel, serial or hardware pin use.
// - Dedicated pin gives clock source high bit in hardware mode.
// - Address/data 4,5 give rx mode bits 0,1; address 5 gives tx mode bit 0.
`ifndef HW_MODE_STRAP_REGS_VH
`define HW_MODE_STRAP_REGS_VH
// Interface select codes {sel1, sel0}
`define IFSEL_PARALLEL   2'h0
`define IFSEL_PARALLEL2  2'h1
`define IFSEL_SERIAL     2'h2
`define IFSEL_HARDWARE   2'h3
// Transmit clock source codes
`define TXSRC_EXT        2'h0
`define TXSRC_PLL        2'h1
`define TXSRC_MCLK       2'h2
`define TXSRC_RCLK       2'h3
// Mode field: bit 3 clear and bit 2 set marks the E1 framing modes
`define MODE_E1_HI       2'h1
`define MODE_SYNC2048    4'h8
// Termination codes
`define TERM_OFF         2'h0
`define TERM_100         2'h1
`define TERM_75          2'h2
`define TERM_120         2'h3
// Resets
`define RST_MODE         4'h0
`define RST_IFMODE       2'h0
`endif

// ### logic/hw_mode_strap_decoder.v
`timescale 1ns/1ns
`default_nettype none
`include "hw_mode_strap_regs.vh"
module hw_mode_strap_decoder #(
   parameter [1:0] SEL_PARALLEL  = `IFSEL_PARALLEL,
   parameter [1:0] SEL_PARALLEL2 = `IFSEL_PARALLEL2,
   parameter [1:0] SEL_SERIAL    = `IFSEL_SERIAL,
   parameter [1:0] SEL_HARDWARE  = `IFSEL_HARDWARE
) (
   // Clock and reset
   input  wire       core_clk,
   input  wire       rst,
   // Interface select pins
   input  wire       host_if_sel0,
   input  wire       host_if_sel1,
   // Shared configuration pins
   input  wire       intPinIn,
   input  wire       chipSelPin,
   input  wire       bus_type_select,
   input  wire       read_strobe_n,
   input  wire       writeStrobePin,
   input  wire       addr_data_bit0,
   input  wire       addr_data_bit1,
   input  wire       addrData4Pin,
   input  wire       addrData5Pin,
   input  wire       addrData6Pin,
   input  wire       addrData7Pin,
   input  wire       addr0Pin,
   input  wire       addr5Pin,
   input  wire       tx_mode_sel_b2,
   input  wire       tx_mode_sel_b1,
   input  wire       tx_clk_src_sel_hi,
   // Clock sources, already in the core domain
   input  wire       ext_tx_clock_in,
   input  wire       pllClk,
   input  wire       scaledMclk,
   input  wire       recoveredClk,
   // Interrupt request from the processor-mode logic
   input  wire       irqReq,
   // Decoded interface mode
   output reg        parallelMode,
   output reg        serialMode,
   output reg        hardwareMode,
   // Processor-mode strobes, qualified by mode
   output reg        chipSelN,
   output reg        readStrobeN,
   output reg        writeStrobeN,
   output reg        busTimingSel,
   output reg        spiMiso,
   output reg        spiMisoOeN,
   output reg        spiMosi,
   output reg        intOut,
   output reg        intOeN,
   // Hardware-mode configuration
   output reg        jitter_atten_clk_sel0,
   output reg        remote_loopback_en,
   output reg        line_code_enable,
   output reg  [3:0] txMode,
   output reg  [3:0] rxMode,
   output reg  [1:0] txClkSrc,
   output reg        txPllRefClk,
   output reg        txClock,
   output reg        pllClkOut,
   output reg  [1:0] txTermSel,
   output reg  [1:0] rxTermSel
);
   wire [15:0] pinRaw = {intPinIn, chipSelPin, bus_type_select, read_strobe_n,
                         writeStrobePin, addr_data_bit0, addr_data_bit1, addrData4Pin,
                         addrData5Pin, addrData6Pin, addrData7Pin, addr0Pin,
                         addr5Pin, tx_mode_sel_b2, tx_mode_sel_b1, tx_clk_src_sel_hi};
   wire [15:0] pinS;
   wire [1:0]  selS;

   // Straps and strobes come from pins, so every one is synchronised
   strap_sync #(.WIDTH(18)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .asyncIn  ({host_if_sel1, host_if_sel0, pinRaw}),
      .syncOut  ({selS, pinS})
   );

   wire sInt  = pinS[15];
   wire sCs   = pinS[14];
   wire sBts  = pinS[13];
   wire sRd   = pinS[12];
   wire sWr   = pinS[11];
   wire sAd0  = pinS[10];
   wire sAd1  = pinS[9];
   wire sAd4  = pinS[8];
   wire sAd5  = pinS[7];
   wire sAd6  = pinS[6];
   wire sAd7  = pinS[5];
   wire sA0   = pinS[4];
   wire sA5   = pinS[3];
   wire sTm2  = pinS[2];
   wire sTm1  = pinS[1];
   wire sTcHi = pinS[0];

   // Unlisted codes fall back to parallel so the part stays reachable by a host
   wire isHw  = (selS == SEL_HARDWARE);
   wire isSer = (selS == SEL_SERIAL) && !isHw;
   wire isPar = !isHw && !isSer;

   // Hardware-mode fields; every one is gated so idle pins cannot leak in
   wire [3:0] txModeD = isHw ? {sWr, sTm2, sTm1, sA5} : `RST_MODE;
   wire [3:0] rxModeD = isHw ? {sAd1, sRd, sAd5, sAd4} : `RST_MODE;
   wire [1:0] srcD    = isHw ? {sTcHi, sAd0} : `TXSRC_EXT;

   function [1:0] termFor;
      input [3:0] mode;
      input       termOff;
      input       e1Sel;
      begin
         if (termOff)
            termFor = `TERM_OFF;
         else if (mode[3:2] == `MODE_E1_HI || mode == `MODE_SYNC2048)
            termFor = e1Sel ? `TERM_120 : `TERM_75;
         else
            termFor = `TERM_100;
      end
   endfunction

   reg txSelClk;
   always @* begin
      case (srcD)
         `TXSRC_EXT:  txSelClk = ext_tx_clock_in;
         `TXSRC_PLL:  txSelClk = pllClk;
         `TXSRC_MCLK: txSelClk = scaledMclk;
         `TXSRC_RCLK: txSelClk = recoveredClk;
         default:     txSelClk = ext_tx_clock_in;
      endcase
   end

   always @(posedge core_clk) begin
      if (rst) begin
         parallelMode          <= 1'b1;
         serialMode            <= 1'b0;
         hardwareMode          <= 1'b0;
         chipSelN              <= 1'b1;
         readStrobeN           <= 1'b1;
         writeStrobeN          <= 1'b1;
         busTimingSel          <= 1'b0;
         spiMiso               <= 1'b0;
         spiMisoOeN            <= 1'b1;
         spiMosi               <= 1'b0;
         intOut                <= 1'b1;
         intOeN                <= 1'b1;
         jitter_atten_clk_sel0 <= 1'b0;
         remote_loopback_en    <= 1'b0;
         line_code_enable      <= 1'b0;
         txMode                <= `RST_MODE;
         rxMode                <= `RST_MODE;
         txClkSrc              <= `TXSRC_EXT;
         txPllRefClk           <= 1'b0;
         txClock               <= 1'b0;
         pllClkOut             <= 1'b0;
         txTermSel             <= `TERM_OFF;
         rxTermSel             <= `TERM_OFF;
      end else begin
         parallelMode          <= isPar;
         serialMode            <= isSer;
         hardwareMode          <= isHw;
         chipSelN              <= isHw ? 1'b1 : sCs;
         readStrobeN           <= isPar ? sRd : 1'b1;
         writeStrobeN          <= isPar ? sWr : 1'b1;
         busTimingSel          <= isPar & sBts;
         // Serial data out drives its pin only while the select is active
         spiMiso               <= isSer & irqReq;
         spiMisoOeN            <= !(isSer && !sCs);
         spiMosi               <= isSer & sAd1;
         // Open-drain interrupt: drive low only, otherwise release the pin
         intOut                <= 1'b0;
         intOeN                <= !(!isHw && irqReq);
         jitter_atten_clk_sel0 <= isHw & sInt;
         remote_loopback_en    <= isHw & sCs;
         line_code_enable      <= isHw & sBts;
         txMode                <= txModeD;
         rxMode                <= rxModeD;
         txClkSrc              <= srcD;
         // Registered clock path: only valid for clocks well below core rate
         txPllRefClk           <= ext_tx_clock_in;
         txClock               <= txSelClk;
         pllClkOut             <= txSelClk;
         txTermSel             <= isHw ? termFor(txModeD, sAd6, sA0)
                                       : `TERM_OFF;
         rxTermSel             <= isHw ? termFor(rxModeD, sAd7, sA0)
                                       : `TERM_OFF;
      end
   end
endmodule
`default_nettype wire

// ### logic/strap_sync.v
`timescale 1ns/1ns
`default_nettype none
// Two-stage synchroniser, one per bit
module strap_sync #(
   parameter WIDTH = 1
) (
   input  wire             core_clk,
   input  wire             rst,
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);
   reg [WIDTH-1:0] meta_q;
   reg [WIDTH-1:0] sync_q;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge core_clk) begin
            if (rst) begin
               meta_q[i] <= 1'b0;
               sync_q[i] <= 1'b0;
            end else begin
               meta_q[i] <= asyncIn[i];
               sync_q[i] <= meta_q[i];
            end
         end
      end
   endgenerate
   assign syncOut = sync_q;
endmodule
`default_nettype wire

// ### verif/hw_mode_strap_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module hw_mode_strap_asserts (
   // Clock, reset and select pins
   input wire logic       core_clk, rst, host_if_sel0, host_if_sel1,
   // Strap pins
   input wire logic       intPinIn, chipSelPin, bus_type_select, read_strobe_n,
   input wire logic       writeStrobePin, addr_data_bit0, addr_data_bit1, addrData4Pin,
   input wire logic       addrData5Pin, addrData6Pin, addrData7Pin, addr0Pin, addr5Pin,
   input wire logic       tx_mode_sel_b2, tx_mode_sel_b1, tx_clk_src_sel_hi,
   // Clock sources
   input wire logic       ext_tx_clock_in, pllClk, scaledMclk, recoveredClk,
   // Decoded outputs
   input wire logic       hardwareMode, jitter_atten_clk_sel0, remote_loopback_en,
   input wire logic       line_code_enable, txPllRefClk, txClock, pllClkOut,
   input wire logic [3:0] txMode, rxMode,
   input wire logic [1:0] txClkSrc, txTermSel, rxTermSel
);
   logic [2:0] age;
   // Keeps three-deep history from reaching back into reset
   always_ff @(posedge core_clk) begin
      if (rst)
         age <= 3'h0;
      else if (age != 3'h7)
         age <= age + 3'h1;
   end
   wire logic ready = (age > 3'h4);
   function automatic logic [1:0] term(input logic [3:0] m, input logic d, input logic e);
      if (d)
         return 2'h0;
      if (m[3:2] == 2'h1 || m == 4'h8)
         return {1'b1, e};
      return 2'h1;
   endfunction
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   hw_decode_a: assert property (ready |-> hardwareMode ==
      $past(host_if_sel0 & host_if_sel1, 3)) else $error("mode decode wrong");
   tx_fields_a: assert property (ready && hardwareMode |-> txMode ==
      $past({writeStrobePin, tx_mode_sel_b2, tx_mode_sel_b1, addr5Pin}, 3)) else $error("tx mode");
   rx_fields_a: assert property (ready && hardwareMode |-> rxMode ==
      $past({addr_data_bit1, read_strobe_n, addrData5Pin, addrData4Pin}, 3)) else $error("rx mode");
   src_strap_a: assert property (ready && hardwareMode |-> txClkSrc ==
      $past({tx_clk_src_sel_hi, addr_data_bit0}, 3)) else $error("clock source strap");
   hw_pins_a: assert property (ready && hardwareMode |-> {jitter_atten_clk_sel0,
      remote_loopback_en, line_code_enable} == $past({intPinIn, chipSelPin, bus_type_select}, 3))
      else $error("hardware pin use");
   unused_quiet_a: assert property (ready && !hardwareMode |-> {txMode, rxMode, txClkSrc,
      txTermSel, rxTermSel, jitter_atten_clk_sel0, remote_loopback_en, line_code_enable} == '0)
      else $error("unused pins leak");
   clk_pick_a: assert property (ready && $stable(txClkSrc) |-> txClock ==
      $past(txClkSrc[1] ? (txClkSrc[0] ? recoveredClk : scaledMclk)
                        : (txClkSrc[0] ? pllClk : ext_tx_clock_in)))
      else $error("transmit clock pick");
   pll_mirror_a: assert property (ready |-> pllClkOut == txClock)
      else $error("pll output differs");
   pll_ref_a: assert property (ready && hardwareMode |->
      txPllRefClk == $past(ext_tx_clock_in)) else $error("pll reference");
   term_pair_a: assert property (ready && hardwareMode |->
      {txTermSel, rxTermSel} ==
      {term(txMode, $past(addrData6Pin, 3), $past(addr0Pin, 3)),
       term(rxMode, $past(addrData7Pin, 3), $past(addr0Pin, 3))}) else $error("termination");
   cover property (hardwareMode && txTermSel == 2'h3 && rxTermSel == 2'h3);
   cover property (hardwareMode && txClkSrc == 2'h3);
   cover property (ready && !hardwareMode);
endmodule
bind hw_mode_strap_decoder hw_mode_strap_asserts checks (.*);
`default_nettype wire

// ### verif/strap_board.sv
`timescale 1ns/1ns
`default_nettype none
module strap_board (
   // Clock
   input  wire logic        core_clk,
   // Wanted interface mode and strap values
   input  wire logic [1:0]  ifSel,
   input  wire logic [15:0] cfg,
   // Pins towards the device
   output logic      [17:0] pin
);
   logic wiggle = 1'b0;
   // Hardware-only pins toggle in port modes, so a leaky decode shows up
   always @(negedge core_clk) begin
      wiggle <= ~wiggle;
   end
   assign pin[12:0]  = {cfg[0], cfg[15:13], cfg[5:4], cfg[7], cfg[8], cfg[3], cfg[6], cfg[12:10]};
   assign pin[15:13] = (ifSel == 2'h3) ? {cfg[9], cfg[1], cfg[2]} : {3{wiggle}};
   assign pin[17:16] = ifSel;
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic        core_clk = 1'b0;
   logic        rst      = 1'b1;
   logic        irqReq   = 1'b1;
   logic [1:0]  ifSel    = 2'h0;
   logic [15:0] cfg      = 16'h0000;
   logic [3:0]  clks     = 4'h0;
   wire  logic [17:0] pin;
   logic        parallelMode, serialMode, hardwareMode, intOeN, jitSel, loopEn, lineEn;
   logic        txPllRefClk, txClock, pllClkOut;
   logic [3:0]  txMode, rxMode;
   logic [1:0]  txClkSrc, txTermSel, rxTermSel;
   logic        chipSelN, readStrobeN, writeStrobeN, busTiming, spiMiso, spiMisoOeN, spiMosi;
   logic        intOut;
   wire  logic [3:0]  modeOut = {parallelMode, serialMode, hardwareMode, intOeN};
   wire  logic [7:0]  portOut = {chipSelN, readStrobeN, writeStrobeN, busTiming, spiMiso,
                                 spiMisoOeN, spiMosi, intOut};
   wire  logic [16:0] cfgOut  = {txMode, rxMode, txClkSrc, txTermSel, rxTermSel, jitSel, loopEn,
                                 lineEn};
   wire  logic [13:0] hwOut   = {intOeN, lineEn, loopEn, jitSel, txClkSrc, rxMode, txMode};
   int          fails = 0;
   int          checkCount = 0;
   // Straps then expected transmit and receive termination codes
   logic [19:0] hwCase [6] = '{20'h0054A, 20'h8154F, 20'hA6F81, 20'h7F030, 20'h1C3B5, 20'h8088F};
   strap_board board (.core_clk(core_clk), .ifSel(ifSel), .cfg(cfg), .pin(pin));
   hw_mode_strap_decoder dut (
      .core_clk(core_clk), .rst(rst), .host_if_sel0(pin[16]), .host_if_sel1(pin[17]),
      .intPinIn(pin[0]), .chipSelPin(pin[1]), .bus_type_select(pin[2]),
      .read_strobe_n(pin[3]), .writeStrobePin(pin[4]), .addr_data_bit0(pin[5]),
      .addr_data_bit1(pin[6]), .addrData4Pin(pin[7]), .addrData5Pin(pin[8]),
      .addrData6Pin(pin[9]), .addrData7Pin(pin[10]), .addr0Pin(pin[11]), .addr5Pin(pin[12]),
      .tx_mode_sel_b2(pin[13]), .tx_mode_sel_b1(pin[14]), .tx_clk_src_sel_hi(pin[15]),
      .ext_tx_clock_in(clks[0]), .pllClk(clks[1]), .scaledMclk(clks[2]), .recoveredClk(clks[3]),
      .irqReq(irqReq), .parallelMode(parallelMode), .serialMode(serialMode),
      .hardwareMode(hardwareMode), .chipSelN(chipSelN), .readStrobeN(readStrobeN),
      .writeStrobeN(writeStrobeN), .busTimingSel(busTiming), .spiMiso(spiMiso),
      .spiMisoOeN(spiMisoOeN), .spiMosi(spiMosi), .intOut(intOut), .intOeN(intOeN),
      .jitter_atten_clk_sel0(jitSel), .remote_loopback_en(loopEn), .line_code_enable(lineEn),
      .txMode(txMode), .rxMode(rxMode), .txClkSrc(txClkSrc), .txPllRefClk(txPllRefClk),
      .txClock(txClock), .pllClkOut(pllClkOut), .txTermSel(txTermSel), .rxTermSel(rxTermSel));
   initial begin
      forever #25 core_clk = ~core_clk;
   end
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      checkCount++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Pins cross a two-flop synchroniser, so four cycles covers the three-edge latency
   task automatic apply(input logic [1:0] s, input logic [15:0] c);
      @(negedge core_clk);
      ifSel = s;
      cfg = c;
      repeat (4) @(negedge core_clk);
   endtask
   task automatic testDone();
      $display("checks %0d mismatches %0d", checkCount, fails);
      if (fails == 0 && checkCount > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      for (int s = 0; s < 3; s++) begin
         apply(s[1:0], 16'hFFFF);
         chk(modeOut, (s == 2) ? 4'h4 : 4'h8);
         chk(cfgOut, 20'h00000);
         // Chip select, read and write straps low so the strobes are seen passing
         apply(s[1:0], 16'hF7B7);
         chk(portOut, (s == 2) ? 8'h6A : 8'h14);
      end
      irqReq = 1'b0;
      repeat (2) @(negedge core_clk);
      chk(modeOut, 4'h5);
      irqReq = 1'b1;
      for (int i = 0; i < 6; i++) begin
         apply(2'h3, hwCase[i][19:4]);
         chk(hwOut, {1'b1, hwCase[i][16:4]});
         chk(portOut, 8'hE4);
         chk({txTermSel, rxTermSel}, hwCase[i][3:0]);
      end
      for (int s = 0; s < 4; s++) begin
         apply(2'h3, {6'h00, s[1:0], 8'h00});
         clks = 4'h1 << s;
         repeat (2) @(negedge core_clk);
         chk({txClock, pllClkOut, txPllRefClk}, {2'b11, s == 0});
         clks = ~(4'h1 << s);
         repeat (2) @(negedge core_clk);
         chk({txClock, pllClkOut, txPllRefClk}, {2'b00, s != 0});
      end
      testDone();
   end
endmodule
`default_nettype wire
